// File: verilog/ncss_cfg.svh
// constants for the narrow memory interface clock and strobe select
// assumes a single core clock drives all logic; included by the ncss_top module
`ifndef NCSS_CFG_SVH
`define NCSS_CFG_SVH

// half periods, in core cycles, of the internally derived input clocks
`define NCSS_CORE4_HALF 2'h2
`define NCSS_CORE6_HALF 2'h3
// reset levels of clocks and active-low strobe pins
`define NCSS_CLK_RST 1'h0
`define NCSS_STROBE_RST 1'h1
// strap pin positions within the external address bus
`define NCSS_STRAP_HI 15
`define NCSS_STRAP_LO 14

`endif

// File: verilog/ncss_pkg.sv
// types shared by the clock and strobe select logic
// assumes the cfg header supplies all numeric constants
`default_nettype none

package ncss_pkg;

    // strap codes on the two upper address pins
    typedef enum logic [1:0] {
        NCSS_SRC_EXT,
        NCSS_SRC_CORE4,
        NCSS_SRC_CORE6,
        NCSS_SRC_RSV
    } ncss_src_type;

    typedef enum logic [1:0] {
        NCSS_RATIO_1,
        NCSS_RATIO_2,
        NCSS_RATIO_4,
        NCSS_RATIO_RSV
    } ncss_ratio_type;

    typedef enum logic [1:0] {
        NCSS_MEM_ASYNC,
        NCSS_MEM_SDRAM,
        NCSS_MEM_SYNC,
        NCSS_MEM_RSV
    } ncss_mem_type;

    typedef struct packed {
        logic [1:0] cnt;
        logic clk;
    } ncss_div_st_type;

    typedef struct packed {
        ncss_src_type strap;
        logic sel_clk;
        logic full_clk;
        logic div_clk;
        logic div_cnt;
        logic pin_a_n;
        logic pin_b_n;
        logic pin_c_n;
        logic fifo_oe_n;
        logic pins_oe;
    } ncss_state_type;

endpackage : ncss_pkg

`default_nettype wire

// File: verilog/ncss_core_div.sv
// square-wave divider of the core clock with a fixed half period
// assumes synchronous active-high reset on the core clock
`timescale 1ns/10ps
`default_nettype none

module ncss_core_div #(
    parameter logic [1:0] HALF_CYCLES = 2'h2
) (
    input wire logic ref_clk, // core clock
    input wire logic rst, // synchronous reset
    output logic clk_out // divided level
);
    ncss_pkg::ncss_div_st_type st_r;
    ncss_pkg::ncss_div_st_type st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (st_r.cnt == HALF_CYCLES - 2'h1)
        begin
            st_nxt.cnt = 2'h0;
            st_nxt.clk = ~st_r.clk;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + 2'h1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign clk_out = st_r.clk;

endmodule : ncss_core_div

`default_nettype wire

// File: verilog/ncss_top.sv
// clock source select, output clocks and shared strobe pin muxing
// assumes the access sequencer supplies active-high strobe requests
// and that the external input clock is below a quarter of ref_clk
`timescale 1ns/10ps
`default_nettype none
`include "ncss_cfg.svh"

// Contract
// - at reset the two strap pins are latched and pick ext pin, core/4 or core/6.
// - strap code zero, or the reserved code, selects the external input clock pin.
// - the divided output clock is the selected clock divided by 1, 2 or 4.
// - the full-rate output clock runs at the selected clock rate undivided.
// - on sync memory the first shared pin is address strobe or read enable by select field.
// - the first shared pin is async read enable, sdram column strobe or sync strobe by type.
// - the second shared pin is async output enable, sdram row strobe or sync output enable.
// - the third shared pin is the write enable for async, sdram and sync memory; the reserved type holds it high.
// - a dedicated sync output enable serves chip space three for a glueless fifo.
module ncss_top (
    input wire logic ref_clk, // core clock, 125 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic ext_input_clock_pin, // external interface clock pin
    input wire logic [15:0] external_address_pins, // address pins, straps on top two
    input wire ncss_pkg::ncss_ratio_type div_ratio_sel, // divided clock ratio
    input wire ncss_pkg::ncss_mem_type mem_type, // memory type being accessed
    input wire logic read_enable_select_field, // sync: 0 address strobe, 1 read enable
    input wire logic bus_release, // release strobe pins, e.g. during hold
    input wire logic async_read_enable, // async read request
    input wire logic async_output_enable, // async output enable request
    input wire logic async_write_enable, // async write request
    input wire logic sdram_column_strobe, // sdram cas request
    input wire logic sdram_row_strobe, // sdram ras request
    input wire logic sdram_write_enable, // sdram we request
    input wire logic sync_address_strobe, // sync address strobe request
    input wire logic sync_read_enable, // sync read enable request
    input wire logic sync_output_enable, // sync output enable request
    input wire logic sync_write_enable, // sync write request
    input wire logic chip_select_space3, // access targets chip space three
    output logic full_rate_out_clock, // undivided interface clock
    output logic divided_out_clock, // divided interface clock
    output logic shared_rd_pin_n, // read / cas / strobe pin, low active
    output logic shared_oe_pin_n, // output enable / ras pin, low active
    output logic shared_we_pin_n, // write enable pin, low active
    output logic strobe_pins_oe, // high while strobe pins are driven
    output logic fifo_output_enable_space3_n // space three fifo oe, low active
);
    //--------------------------------------------------------------
    // state
    //--------------------------------------------------------------
    ncss_pkg::ncss_state_type st_r;
    ncss_pkg::ncss_state_type st_nxt;
    logic [1:0] core_clk;
    logic src_clk;
    logic sel_rise;

    // per-type pin meaning; one decode reused for all three pins
    function automatic logic pick_by_type(
        input ncss_pkg::ncss_mem_type t,
        input logic a_req,
        input logic d_req,
        input logic s_req
    );
        logic r;
        r = 1'b0;
        unique case (t)
            ncss_pkg::NCSS_MEM_ASYNC: r = a_req;
            ncss_pkg::NCSS_MEM_SDRAM: r = d_req;
            ncss_pkg::NCSS_MEM_SYNC: r = s_req;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : pick_by_type

    //--------------------------------------------------------------
    // core-derived clocks
    //--------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_core_div
            ncss_core_div #(
                .HALF_CYCLES(gi == 0 ? `NCSS_CORE4_HALF : `NCSS_CORE6_HALF)
            ) u_div (
                .ref_clk(ref_clk),
                .rst(rst),
                .clk_out(core_clk[gi])
            );
        end
    endgenerate

    //--------------------------------------------------------------
    // next state
    //--------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r.strap)
            ncss_pkg::NCSS_SRC_CORE4: src_clk = core_clk[0];
            ncss_pkg::NCSS_SRC_CORE6: src_clk = core_clk[1];
            default: src_clk = ext_input_clock_pin;
        endcase
        st_nxt.sel_clk = src_clk;
        st_nxt.full_clk = st_r.sel_clk;
        sel_rise = st_r.sel_clk & ~st_r.full_clk;
        unique case (div_ratio_sel)
            ncss_pkg::NCSS_RATIO_1:
            begin
                st_nxt.div_clk = st_r.sel_clk;
                st_nxt.div_cnt = 1'b0;
            end
            ncss_pkg::NCSS_RATIO_2:
            begin
                if (sel_rise)
                begin
                    st_nxt.div_clk = ~st_r.div_clk;
                end
            end
            default:
            begin
                if (sel_rise)
                begin
                    st_nxt.div_cnt = ~st_r.div_cnt;
                    if (st_r.div_cnt)
                    begin
                        st_nxt.div_clk = ~st_r.div_clk;
                    end
                end
            end
        endcase
        st_nxt.pin_a_n = ~pick_by_type(mem_type, async_read_enable, sdram_column_strobe,
            read_enable_select_field ? sync_read_enable : sync_address_strobe);
        st_nxt.pin_b_n = ~pick_by_type(mem_type, async_output_enable, sdram_row_strobe,
            sync_output_enable);
        st_nxt.pin_c_n = ~pick_by_type(mem_type, async_write_enable, sdram_write_enable,
            sync_write_enable);
        // fifo oe on space three only
        st_nxt.fifo_oe_n = ~(pick_by_type(mem_type, 1'b0, 1'b0, sync_output_enable)
            & chip_select_space3);
        st_nxt.pins_oe = ~bus_release;
        if (rst)
        begin
            st_nxt.sel_clk = `NCSS_CLK_RST;
            st_nxt.full_clk = `NCSS_CLK_RST;
            st_nxt.div_clk = `NCSS_CLK_RST;
            st_nxt.div_cnt = 1'b0;
            st_nxt.pin_a_n = `NCSS_STROBE_RST;
            st_nxt.pin_b_n = `NCSS_STROBE_RST;
            st_nxt.pin_c_n = `NCSS_STROBE_RST;
            st_nxt.fifo_oe_n = `NCSS_STROBE_RST;
            st_nxt.pins_oe = 1'b0;
            st_nxt.strap = ncss_pkg::ncss_src_type'(
                external_address_pins[`NCSS_STRAP_HI:`NCSS_STRAP_LO]);
        end
    end

    // reset is folded into st_nxt so straps can be sampled synchronously
    always_ff @(posedge ref_clk)
    begin
        st_r <= st_nxt;
    end

    assign full_rate_out_clock = st_r.full_clk;
    assign divided_out_clock = st_r.div_clk;
    assign shared_rd_pin_n = st_r.pin_a_n;
    assign shared_oe_pin_n = st_r.pin_b_n;
    assign shared_we_pin_n = st_r.pin_c_n;
    assign strobe_pins_oe = st_r.pins_oe;
    assign fifo_output_enable_space3_n = st_r.fifo_oe_n;

    //--------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_strap_held:
        assert property (!$past(rst) |-> $stable(st_r.strap))
        else $error("strap changed outside reset");
    a_core4_period:
        assert property ((st_r.strap == ncss_pkg::NCSS_SRC_CORE4) && $rose(st_r.sel_clk)
            |-> ##1 st_r.sel_clk ##1 !st_r.sel_clk)
        else $error("core/4 source half period wrong");
    a_core6_period:
        assert property ((st_r.strap == ncss_pkg::NCSS_SRC_CORE6) && $rose(st_r.sel_clk)
            |-> st_r.sel_clk[*3] ##1 !st_r.sel_clk)
        else $error("core/6 source half period wrong");
    a_ext_default:
        assert property ((st_r.strap == ncss_pkg::NCSS_SRC_EXT)
            |=> st_r.sel_clk == $past(ext_input_clock_pin))
        else $error("ext pin not selected");
    a_full_follow:
        assert property (full_rate_out_clock == $past(st_r.sel_clk))
        else $error("full rate clock not following source");
    a_ratio_one:
        assert property ((div_ratio_sel == ncss_pkg::NCSS_RATIO_1)
            |=> divided_out_clock == full_rate_out_clock)
        else $error("ratio one clock differs");
    a_ratio_two:
        assert property ((div_ratio_sel == ncss_pkg::NCSS_RATIO_2) && sel_rise
            |=> divided_out_clock != $past(divided_out_clock))
        else $error("ratio two did not toggle");
    a_sync_strobe:
        assert property ((mem_type == ncss_pkg::NCSS_MEM_SYNC) && !read_enable_select_field
            |=> shared_rd_pin_n == !$past(sync_address_strobe))
        else $error("sync address strobe wrong");
    a_sync_rden:
        assert property ((mem_type == ncss_pkg::NCSS_MEM_SYNC) && read_enable_select_field
            |=> shared_rd_pin_n == !$past(sync_read_enable))
        else $error("sync read enable wrong");
    a_sdram_cas:
        assert property ((mem_type == ncss_pkg::NCSS_MEM_SDRAM)
            |=> shared_rd_pin_n == !$past(sdram_column_strobe))
        else $error("cas pin wrong");
    a_async_oe:
        assert property ((mem_type == ncss_pkg::NCSS_MEM_ASYNC)
            |=> shared_oe_pin_n == !$past(async_output_enable))
        else $error("async oe pin wrong");
    a_sync_we:
        assert property ((mem_type == ncss_pkg::NCSS_MEM_SYNC)
            |=> shared_we_pin_n == !$past(sync_write_enable))
        else $error("sync we pin wrong");
    a_fifo_oe:
        assert property (!chip_select_space3 |=> fifo_output_enable_space3_n)
        else $error("fifo oe outside space three");
    a_fifo_drive:
        assert property ((mem_type == ncss_pkg::NCSS_MEM_SYNC) && sync_output_enable
            && chip_select_space3 |=> !fifo_output_enable_space3_n)
        else $error("fifo oe not driven in space three");

    c_core4: cover property (st_r.strap == ncss_pkg::NCSS_SRC_CORE4 && $rose(st_r.sel_clk));
    c_core6: cover property (st_r.strap == ncss_pkg::NCSS_SRC_CORE6 && $rose(st_r.sel_clk));
    c_ratio4: cover property (div_ratio_sel == ncss_pkg::NCSS_RATIO_4 && $rose(divided_out_clock));
    c_fifo: cover property (!fifo_output_enable_space3_n);

endmodule : ncss_top

`default_nettype wire

// File: verilog/README_unused.sv
// no code lives here; kept empty on purpose
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: sim/ncss_mem_partner.sv
// far-side model: free-running external interface clock, strap resistors, strobe pull-ups
// assumes the bench picks the strap code while reset is high
`timescale 1ns/10ps
`default_nettype none

module ncss_mem_partner (
    input wire logic rst, // device reset, active high
    input wire logic [1:0] strap_code, // resistor strap level
    input wire logic [13:0] addr_low, // low address bits
    input wire logic [2:0] strobe_n, // shared strobe pins as driven
    input wire logic strobe_oe, // device drives the strobe pins
    output logic [2:0] strobe_seen_n, // strobe levels at the memory
    output logic ext_clk, // external interface clock
    output logic [15:0] addr_pins // address pins seen by the device
);
    // ----------
    // clock
    // ----------
    // off-grid phase keeps every edge clear of the core clock edges
    initial
    begin
        ext_clk = 1'h0;
        #0.25;
        forever #25.5 ext_clk = ~ext_clk;
    end
    // straps valid in reset only
    // inverted levels afterwards make any late re-latch visible
    assign addr_pins = rst ? {strap_code, addr_low} : {~strap_code, addr_low};
    // released strobe pins float up to their pull-ups
    assign strobe_seen_n = strobe_oe ? strobe_n : 3'h7;
endmodule : ncss_mem_partner
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the clock source select and shared strobe pins
// assumes the partner model supplies the external clock and strap levels
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic [1:0] strap = 2'h0;
    logic [13:0] addr_lo = 14'h0;
    ncss_pkg::ncss_ratio_type ratio = ncss_pkg::NCSS_RATIO_1;
    ncss_pkg::ncss_mem_type mt = ncss_pkg::NCSS_MEM_ASYNC;
    logic rsel = 1'h0;
    logic rel = 1'h0;
    logic cs3 = 1'h0;
    logic [9:0] rq = 10'h0;
    logic ext_clk, full, divc, rd_n, oe_n, we_n, pins_oe, fifo_n;
    logic [15:0] addr;
    logic [2:0] seen_n;
    logic [2:0] ext_h = 3'h0;
    int n_errors = 0;
    int n_tests = 0;
    int seed = 75373;
    int hi, per;

    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) ext_h <= {ext_h[1:0], ext_clk};

    ncss_mem_partner mem_u (.rst(rst), .strap_code(strap), .addr_low(addr_lo),
        .strobe_n({rd_n, oe_n, we_n}), .strobe_oe(pins_oe), .strobe_seen_n(seen_n),
        .ext_clk(ext_clk), .addr_pins(addr));
    ncss_top dut_u (.ref_clk(ref_clk), .rst(rst), .ext_input_clock_pin(ext_clk),
        .external_address_pins(addr), .div_ratio_sel(ratio), .mem_type(mt),
        .read_enable_select_field(rsel), .bus_release(rel),
        .async_read_enable(rq[0]), .async_output_enable(rq[1]), .async_write_enable(rq[2]),
        .sdram_column_strobe(rq[3]), .sdram_row_strobe(rq[4]), .sdram_write_enable(rq[5]),
        .sync_address_strobe(rq[6]), .sync_read_enable(rq[7]), .sync_output_enable(rq[8]),
        .sync_write_enable(rq[9]), .chip_select_space3(cs3), .full_rate_out_clock(full),
        .divided_out_clock(divc), .shared_rd_pin_n(rd_n), .shared_oe_pin_n(oe_n),
        .shared_we_pin_n(we_n), .strobe_pins_oe(pins_oe),
        .fifo_output_enable_space3_n(fifo_n));

    // ----------
    // helpers
    // ----------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("counts: tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : final_report

    task automatic do_reset(input logic [1:0] s);
        @(posedge ref_clk);
        rst <= 1'h1;
        strap <= s;
        repeat (4) @(posedge ref_clk);
        #1;
        chk({1'h0, full, divc, rd_n, oe_n, we_n, pins_oe, fifo_n}, 8'h1D, "reset levels");
        @(posedge ref_clk);
        rst <= 1'h0;
    endtask : do_reset

    // cycles from one rising edge to the next, and the high part of it
    task automatic clk_meas(input logic use_div, output int h, output int p);
        logic s0, s1;
        s0 = 1'h1;
        h = 0;
        p = -1;
        for (int k = 0; k < 160; k++)
        begin
            @(posedge ref_clk);
            #1;
            s1 = use_div ? divc : full;
            if (!s0 && s1 && p >= 0)
                break;
            if (!s0 && s1)
                p = 0;
            if (p >= 0)
            begin
                p++;
                h += s1;
            end
            s0 = s1;
        end
    endtask : clk_meas

    function automatic logic [7:0] exp_pins(logic [1:0] m, logic [9:0] q, logic rs, logic c3,
        logic rl);
        logic [2:0] a;
        a = 3'h0;
        case (m)
            ncss_pkg::NCSS_MEM_ASYNC: a = {q[0], q[1], q[2]};
            ncss_pkg::NCSS_MEM_SDRAM: a = {q[3], q[4], q[5]};
            ncss_pkg::NCSS_MEM_SYNC: a = {rs ? q[7] : q[6], q[8], q[9]};
            default: a = 3'h0;
        endcase
        return {3'h0, rl ? 3'h7 : ~a, ~rl, ~(m == ncss_pkg::NCSS_MEM_SYNC && q[8] && c3)};
    endfunction : exp_pins

    // first eight cycles drive every type with all requests, then random traffic
    task automatic strobe_run(input int n);
        logic [7:0] e, e_prev;
        logic [31:0] r;
        e_prev = 8'h0;
        for (int k = 0; k <= n; k++)
        begin
            @(posedge ref_clk);
            r = $random(seed);
            if (k < 8)
                r = {16'h0, 2'h0, 1'h1, k[2], 10'h3FF, k[1:0]};
            mt <= ncss_pkg::ncss_mem_type'(r[1:0]);
            rq <= r[11:2];
            rsel <= r[12];
            cs3 <= r[13];
            rel <= (r[17:14] == 4'h0) && (k >= 8);
            addr_lo <= r[31:18];
            e = exp_pins(r[1:0], r[11:2], r[12], r[13], (r[17:14] == 4'h0) && (k >= 8));
            #1;
            if (k > 0)
                chk({3'h0, seen_n, pins_oe, fifo_n}, e_prev, "pins");
            e_prev = e;
        end
    endtask : strobe_run

    // ----------
    // sequence
    // ----------
    initial
    begin
        fork
            begin
                #100000;
                n_errors++;
                $display("ERROR t=%0t watchdog expired", $time);
                final_report();
            end
        join_none
        for (int s = 0; s < 4; s++)
        begin
            do_reset(s[1:0]);
            repeat (12) @(posedge ref_clk);
            if (s == 1 || s == 2)
            begin
                clk_meas(1'h0, hi, per);
                chk(8'(per), (s == 1) ? 8'h4 : 8'h6, "full period");
                chk(8'(hi), (s == 1) ? 8'h2 : 8'h3, "full high time");
            end
            else
            begin
                for (int k = 0; k < 40; k++)
                begin
                    @(posedge ref_clk);
                    #1;
                    chk({7'h0, full}, {7'h0, ext_h[1]}, "ext clock follow");
                end
            end
            $display("test strap %0d done", s);
        end
        do_reset(2'h1);
        for (int r = 0; r < 4; r++)
        begin
            @(posedge ref_clk);
            ratio <= ncss_pkg::ncss_ratio_type'(r[1:0]);
            repeat (24) @(posedge ref_clk);
            clk_meas(1'h1, hi, per);
            chk(8'(per), (r == 0) ? 8'h4 : ((r == 1) ? 8'h8 : 8'h10), "div period");
            chk(8'(hi), (r == 0) ? 8'h2 : ((r == 1) ? 8'h4 : 8'h8), "div high time");
            #1;
            if (r == 0)
                chk({7'h0, divc}, {7'h0, full}, "ratio one");
            $display("test ratio code %0d done", r);
        end
        strobe_run(400);
        $display("test strobe pins done");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
